// ==== design/lnbr_deglitch.sv ====
module lnbr_deglitch (
    // clock and reset
    input  wire logic    clk_i,
    input  wire logic    reset_n_i,
    // filter port
    lnbr_deglitch_if.filt dg
);
    import lnbr_pkg::*;

    logic [PDO_CNT_W-1:0] count;
    logic                 flag;
    wire                  done = (count == PDO_CNT_W'(PDO_DEGLITCH_CYC));

    // flag only after the raw condition has lasted the whole interval
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !dg.raw) begin
            count <= '0;
            flag  <= 1'b0;
        end else if (!done) begin
            count <= count + PDO_CNT_W'(1);
        end else begin
            flag <= 1'b1;
        end
    end

    assign dg.flag = flag;
endmodule : lnbr_deglitch

// ==== design/lnbr_deglitch_if.sv ====
interface lnbr_deglitch_if;
    // raw condition in, filtered flag out
    logic raw;
    logic flag;
    modport filt (input raw, output flag);
    modport user (output raw, input flag);
endinterface : lnbr_deglitch_if

// ==== design/lnbr_pkg.sv ====
package lnbr_pkg;
    // register addresses on the serial register port
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h05;
    // config field positions
    localparam int CFG_DIAG_A   = 0;
    localparam int CFG_OVL_LATCH = 3;
    localparam int CFG_DIAG_B   = 4;
    localparam int CFG_THERMAL_LATCH_POLICY    = 6;
    localparam int CFG_COMP     = 7;
    // writable bits mask: reserved 1, 2, 5 forced to zero
    localparam logic [7:0] CFG_WMASK = 8'hd9;
    // reset values
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] OUTPUT_VOLTAGE_SELECT_RESET   = 4'h0;
    // pull-down overcurrent deglitch
    localparam int CLK_HZ         = 10_000_000;
    localparam int PDO_DEGLITCH_US = 10;
    localparam int PDO_DEGLITCH_CYC = (PDO_DEGLITCH_US * (CLK_HZ / 1_000_000) > 0) ?
                                      PDO_DEGLITCH_US * (CLK_HZ / 1_000_000) : 1;
    localparam int PDO_CNT_W = 8;
    // per-channel output state
    typedef enum logic [1:0] {
        LNBR_OUT_ON  = 2'b00,
        LNBR_OUT_OVL = 2'b01,
        LNBR_OUT_OFF = 2'b11
    } lnbr_out_e;
endpackage : lnbr_pkg

// ==== design/lnbr_regs.sv ====
// How it works
// - config register at 0x5, read and write
// - bits 0,4 enable low-current diagnostic A/B
// - latch mode: overload clears channel selection
// - auto mode: overload clear restores old selection
// - thermal latch: clear all selections, outputs off
// - thermal auto mode restores outputs by itself
// - bit 7 selects converter compensation
// - status register at 0x0, read only
// - status bits 0,1 overload A/B
// - status bits 2,3 undervoltage A/B
// - bits 4,5 pull-down overcurrent after deglitch
// - bit 6 overtemperature with hysteresis
// - bit 7 supply loss below threshold
// - status bits reset to zero
module lnbr_regs (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // register port from the serial engine
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_wr_done_i,
    input  wire logic       reg_rd_i,
    output logic [7:0]      reg_rdata_o,
    // output voltage select writes from the data registers
    input  wire logic [3:0] output_voltage_select_a_i,
    input  wire logic [3:0] output_voltage_select_b_i,
    input  wire logic       output_voltage_select_a_wr_i,
    input  wire logic       output_voltage_select_b_wr_i,
    // analogue comparator inputs
    input  wire logic       overload_a_i,
    input  wire logic       overload_b_i,
    input  wire logic       undervolt_a_i,
    input  wire logic       undervolt_b_i,
    input  wire logic       pulldown_oc_a_i,
    input  wire logic       pulldown_oc_b_i,
    input  wire logic       temp_hot_i,
    input  wire logic       temp_cool_i,
    input  wire logic       supply_low_i,
    // control outputs
    output logic [3:0]      output_voltage_select_a_o,
    output logic [3:0]      output_voltage_select_b_o,
    output logic            supply_enable_a_o,
    output logic            supply_enable_b_o,
    output logic            low_current_diag_enable_a_o,
    output logic            low_current_diag_enable_b_o,
    output logic            stepup_comp_ceramic_o
);
    import lnbr_pkg::*;

    logic [7:0] cfg;
    logic [7:0] staged;
    logic       staged_pend;
    logic       overtemperature_flag;
    logic [7:0] status;
    logic [3:0] output_voltage_select_a;
    logic [3:0] output_voltage_select_b;

    // pull-down overcurrent filters, one per channel
    lnbr_deglitch_if dg_a ();
    lnbr_deglitch_if dg_b ();
    assign dg_a.raw = pulldown_oc_a_i;
    assign dg_b.raw = pulldown_oc_b_i;
    lnbr_deglitch u_dg_a (.clk_i(clk_i), .reset_n_i(reset_n_i), .dg(dg_a));
    lnbr_deglitch u_dg_b (.clk_i(clk_i), .reset_n_i(reset_n_i), .dg(dg_b));

    // decode
    wire sel_cfg    = (reg_addr_i == ADDR_CONFIG);
    wire sel_status = (reg_addr_i == ADDR_STATUS);
    wire cfg_wr     = reg_wr_i && sel_cfg;

    // stage config data, apply when the transaction ends
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            staged      <= CFG_RESET;
            staged_pend <= 1'b0;
        end else if (cfg_wr) begin
            staged      <= reg_wdata_i & CFG_WMASK;
            staged_pend <= 1'b1;
        end else if (reg_wr_done_i) begin
            staged_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i)
            cfg <= CFG_RESET;
        else if (reg_wr_done_i && staged_pend)
            cfg <= staged;
    end

    // hysteresis: set above hot, clear only below cool
    always_ff @(posedge clk_i) begin
        if (!reset_n_i)
            overtemperature_flag <= 1'b0;
        else if (temp_hot_i)
            overtemperature_flag <= 1'b1;
        else if (temp_cool_i)
            overtemperature_flag <= 1'b0;
    end

    wire [7:0] next_status = {supply_low_i, overtemperature_flag, dg_b.flag, dg_a.flag,
                              undervolt_b_i, undervolt_a_i, overload_b_i, overload_a_i};

    always_ff @(posedge clk_i) begin
        if (!reset_n_i)
            status <= STATUS_RESET;
        else
            status <= next_status;
    end

    wire ovl_latch   = cfg[CFG_OVL_LATCH];
    wire thermal_latch_policy_latch = cfg[CFG_THERMAL_LATCH_POLICY];
    wire thermal_latch_policy_trip  = overtemperature_flag;

    // latch modes clear stored selection; trip beats host write
    wire clr_a = (ovl_latch && overload_a_i) || (thermal_latch_policy_latch && thermal_latch_policy_trip);
    wire clr_b = (ovl_latch && overload_b_i) || (thermal_latch_policy_latch && thermal_latch_policy_trip);

    // stored voltage selections
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            output_voltage_select_a <= OUTPUT_VOLTAGE_SELECT_RESET;
            output_voltage_select_b <= OUTPUT_VOLTAGE_SELECT_RESET;
        end else begin
            if (clr_a)
                output_voltage_select_a <= OUTPUT_VOLTAGE_SELECT_RESET;
            else if (output_voltage_select_a_wr_i)
                output_voltage_select_a <= output_voltage_select_a_i;
            if (clr_b)
                output_voltage_select_b <= OUTPUT_VOLTAGE_SELECT_RESET;
            else if (output_voltage_select_b_wr_i)
                output_voltage_select_b <= output_voltage_select_b_i;
        end
    end

    // per-channel overload recovery, index 0 is channel A, 1 is channel B
    wire [1:0] ovl_now = {overload_b_i, overload_a_i};
    wire [1:0] sel_wr  = {output_voltage_select_b_wr_i, output_voltage_select_a_wr_i};
    wire [1:0] sel_clr = {clr_b, clr_a};
    wire [1:0] chan_on;

    // each channel recovers on its own
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        lnbr_out_e state;
        lnbr_out_e next_state;

        // next state; a rewrite during the fault is lost, so stay off
        always_comb begin
            next_state = state;
            case (state)
                LNBR_OUT_ON: begin
                    if (ovl_now[ch])
                        next_state = ovl_latch ? LNBR_OUT_OFF : LNBR_OUT_OVL;
                end
                LNBR_OUT_OVL: begin
                    if (!ovl_now[ch])
                        next_state = LNBR_OUT_ON;
                    else if (ovl_latch)
                        next_state = LNBR_OUT_OFF;
                end
                // latched off until a selection lands, or until auto mode sees no overload
                LNBR_OUT_OFF: begin
                    if (sel_wr[ch] && !sel_clr[ch])
                        next_state = LNBR_OUT_ON;
                    else if (!ovl_latch && !ovl_now[ch])
                        next_state = LNBR_OUT_ON;
                end
                default: begin
                    next_state = LNBR_OUT_ON;
                end
            endcase
        end

        // state register
        always_ff @(posedge clk_i) begin
            if (!reset_n_i)
                state <= LNBR_OUT_ON;
            else
                state <= next_state;
        end

        // overload state stays armed; the live overload term gates it
        assign chan_on[ch] = (state != LNBR_OUT_OFF);
    end : g_chan

    // a zero selection means the output is off
    wire output_voltage_select_a_set = (output_voltage_select_a != OUTPUT_VOLTAGE_SELECT_RESET);
    wire output_voltage_select_b_set = (output_voltage_select_b != OUTPUT_VOLTAGE_SELECT_RESET);

    // auto modes keep selection, enable returns when fault clears
    assign supply_enable_a_o = chan_on[0] && !overload_a_i && !thermal_latch_policy_trip && output_voltage_select_a_set;
    assign supply_enable_b_o = chan_on[1] && !overload_b_i && !thermal_latch_policy_trip && output_voltage_select_b_set;
    assign output_voltage_select_a_o = output_voltage_select_a;
    assign output_voltage_select_b_o = output_voltage_select_b;

    assign low_current_diag_enable_a_o = cfg[CFG_DIAG_A];
    assign low_current_diag_enable_b_o = cfg[CFG_DIAG_B];
    assign stepup_comp_ceramic_o = cfg[CFG_COMP];

    // read mux, status read only; unmapped reads zero
    wire [7:0] rd_mux = sel_status ? status : (sel_cfg ? cfg : 8'h00);

    // registered read data
    always_ff @(posedge clk_i) begin
        if (!reset_n_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
            reg_rdata_o <= rd_mux;
    end
endmodule : lnbr_regs

// ==== verif/lnbr_host_model.sv ====
module lnbr_host_model
    import lnbr_pkg::*;
(
    // clock and register port
    input  wire logic       clk_i,
    output logic [7:0]      addr_o = 8'h00,
    output logic [7:0]      wdata_o = 8'h00,
    output logic            wr_o = 1'b0,
    output logic            done_o = 1'b0,
    output logic            rd_o = 1'b0,
    input  wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // byte then end of transaction; released lines show inverse
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i) #1;
        addr_o = a;
        wdata_o = (a == ADDR_CONFIG) ? d & CFG_WMASK : d;
        wr_o = 1'b1;
        @(posedge clk_i) #1;
        wr_o = 1'b0;
        done_o = 1'b1;
        @(posedge clk_i) #1;
        done_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    // read answer lands one cycle after request
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_i) #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i) #1;
        rd_o = 1'b0;
        addr_o = ~a;
        q = rdata_i;
    endtask
endmodule // lnbr_host_model

// ==== verif/lnbr_regs_asserts.sv ====
module lnbr_regs_asserts
    import lnbr_pkg::*;
(
    // clock and reset
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_done_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // selection writes
    input wire logic [3:0] output_voltage_select_a_i,
    input wire logic       output_voltage_select_a_wr_i,
    // comparators
    input wire logic       overload_a_i,
    input wire logic       overload_b_i,
    input wire logic       undervolt_a_i,
    input wire logic       undervolt_b_i,
    input wire logic       temp_hot_i,
    input wire logic       temp_cool_i,
    input wire logic       supply_low_i,
    // controls
    input wire logic [3:0] output_voltage_select_a_o,
    input wire logic       supply_enable_a_o,
    input wire logic       supply_enable_b_o,
    input wire logic       low_current_diag_enable_a_o,
    input wire logic       low_current_diag_enable_b_o,
    input wire logic       stepup_comp_ceramic_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // visible config bits and decoded reads
    wire logic [2:0] cf = {stepup_comp_ceramic_o, low_current_diag_enable_b_o,
                           low_current_diag_enable_a_o};
    wire logic rs = reg_rd_i && reg_addr_i == ADDR_STATUS;
    wire logic rc = reg_rd_i && reg_addr_i == ADDR_CONFIG;
    property p_commit; !$past(reg_wr_done_i) |-> $stable(cf); endproperty
    a_commit: assert property (p_commit) else $error("config moved without commit");
    property p_rdst; rs |=> reg_rdata_o[3:0] == $past({undervolt_b_i, undervolt_a_i,
        overload_b_i, overload_a_i}, 2) && reg_rdata_o[7] == $past(supply_low_i, 2); endproperty
    a_rdst: assert property (p_rdst) else $error("status read wrong");
    property p_rdcf;
        rc |=> (reg_rdata_o & 8'hb7) == {cf[2], 2'b0, cf[1], 3'b0, cf[0]};
    endproperty
    a_rdcf: assert property (p_rdcf) else $error("config read wrong");
    property p_unm; reg_rd_i && !rs && !rc |=> reg_rdata_o == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_ovl; overload_a_i && $past(overload_a_i) |-> !supply_enable_a_o; endproperty
    a_ovl: assert property (p_ovl) else $error("output on in overload");
    property p_hot; temp_hot_i [*3] |-> !supply_enable_a_o && !supply_enable_b_o; endproperty
    a_hot: assert property (p_hot) else $error("output on while hot");
    property p_zero; output_voltage_select_a_o == 4'h0 |-> !supply_enable_a_o; endproperty
    a_zero: assert property (p_zero) else $error("output on with no selection");
    property p_output_voltage_select;
        output_voltage_select_a_wr_i && temp_cool_i && $past(temp_cool_i) && $past(temp_cool_i, 2)
        && !$past(temp_hot_i) && !overload_a_i && !$past(overload_a_i)
        |=> output_voltage_select_a_o == $past(output_voltage_select_a_i);
    endproperty
    a_output_voltage_select: assert property (p_output_voltage_select) else $error("selection not loaded");
endmodule // lnbr_regs_asserts

bind lnbr_regs lnbr_regs_asserts u_chk (.*);

// ==== verif/lnbr_regs_tb_top.sv ====
module lnbr_regs_tb_top;
    import lnbr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, reset_n_i = 0, vwa = 0, vwb = 0, ola = 0, olb = 0, uva = 0, uvb = 0;
    logic pda = 0, pdb = 0, hot = 0, cool = 1, low = 0, wr, done, rd, ena, enb, dga, dgb, cmp;
    logic [3:0] va = 0, vb = 0, sa, sb;
    logic [7:0] addr, wdata, rdata, q;
    logic [7:0] bits [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80, 8'h40};
    int mismatches = 0, check_count = 0, cyc = 0;
    // clock and hang guard
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    lnbr_host_model u_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .done_o(done), .rd_o(rd), .rdata_i(rdata));
    lnbr_regs u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_wr_done_i(done), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .output_voltage_select_a_i(va), .output_voltage_select_b_i(vb), .output_voltage_select_a_wr_i(vwa),
        .output_voltage_select_b_wr_i(vwb), .overload_a_i(ola), .overload_b_i(olb), .undervolt_a_i(uva),
        .undervolt_b_i(uvb), .pulldown_oc_a_i(pda), .pulldown_oc_b_i(pdb), .temp_hot_i(hot),
        .temp_cool_i(cool), .supply_low_i(low), .output_voltage_select_a_o(sa),
        .output_voltage_select_b_o(sb), .supply_enable_a_o(ena), .supply_enable_b_o(enb),
        .low_current_diag_enable_a_o(dga), .low_current_diag_enable_b_o(dgb),
        .stepup_comp_ceramic_o(cmp));
    task automatic chk(input string n, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, e);
        u_host.rd(a, q);
        chk(n, e, q);
    endtask
    task automatic oc(input logic [7:0] s, input logic [1:0] e);
        chk("sel", s, {sa, sb});
        chk("en", {6'h0, e}, {6'h0, ena, enb});
    endtask
    // comparator levels; bit 6 is hot, cool its inverse
    task automatic st(input logic [7:0] v);
        @(posedge clk_i) #1;
        {low, hot, pdb, pda, uvb, uva, olb, ola} = v;
        cool = !v[6];
        repeat (3) @(posedge clk_i);
    endtask
    task automatic vs(input logic [3:0] a, b);
        @(posedge clk_i) #1;
        {va, vb, vwa, vwb} = {a, b, 2'b11};
        @(posedge clk_i) #1;
        {va, vb, vwa, vwb} = {~a, ~b, 2'b00};
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        #1 reset_n_i = 1;
        rchk("status", ADDR_STATUS, STATUS_RESET);
        rchk("config", ADDR_CONFIG, CFG_RESET);
        $display("reset test done");
        u_host.wr(ADDR_CONFIG, 8'h99);
        chk("cfg_out", 8'h07, {cmp, dgb, dga});
        rchk("config", ADDR_CONFIG, 8'h99);
        u_host.wr(ADDR_STATUS, 8'h55);
        rchk("status", ADDR_STATUS, 8'h00);
        rchk("unmapped", 8'h07, 8'h00);
        u_host.wr(ADDR_CONFIG, 8'h00);
        chk("cfg_out", 8'h00, {cmp, dgb, dga});
        $display("config test done");
        foreach (bits[i]) begin
            st(bits[i]);
            rchk("status", ADDR_STATUS, bits[i]);
        end
        hot = 0;
        repeat (3) @(posedge clk_i);
        rchk("hyst", ADDR_STATUS, 8'h40);
        st(8'h30);
        // deglitch window: read before it ends, then after
        repeat (PDO_DEGLITCH_CYC - 10) @(posedge clk_i);
        rchk("pulldown", ADDR_STATUS, 8'h00);
        repeat (20) @(posedge clk_i);
        rchk("pulldown", ADDR_STATUS, 8'h30);
        st(8'h00);
        $display("status test done");
        u_host.wr(ADDR_CONFIG, 8'h08);
        vs(4'h3, 4'h5);
        st(8'h01);
        oc(8'h05, 2'b01);
        st(8'h00);
        oc(8'h05, 2'b01);
        vs(4'h3, 4'h5);
        oc(8'h35, 2'b11);
        u_host.wr(ADDR_CONFIG, 8'h00);
        st(8'h01);
        oc(8'h35, 2'b01);
        st(8'h00);
        oc(8'h35, 2'b11);
        $display("overload test done");
        u_host.wr(ADDR_CONFIG, 8'h40);
        st(8'h40);
        oc(8'h00, 2'b00);
        st(8'h00);
        vs(4'h3, 4'h5);
        oc(8'h35, 2'b11);
        u_host.wr(ADDR_CONFIG, 8'h00);
        st(8'h40);
        oc(8'h35, 2'b00);
        st(8'h00);
        oc(8'h35, 2'b11);
        $display("thermal test done");
        // reset in mid-run clears config, selections, read data
        u_host.wr(ADDR_CONFIG, 8'h99);
        rchk("config", ADDR_CONFIG, 8'h99);
        vs(4'h3, 4'h5);
        reset_n_i = 0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("cfg_out", 8'h00, {cmp, dgb, dga});
        chk("sel", 8'h00, {sa, sb});
        chk("rdata", 8'h00, rdata);
        reset_n_i = 1;
        rchk("config", ADDR_CONFIG, CFG_RESET);
        $display("mid-run reset test done");
        tally_and_finish();
    end
endmodule // lnbr_regs_tb_top
